/* logic/mpi_chan.sv */
// Purpose: one phase channel: forced low, compare, sample, balance filter
// Assumes: i_term is one-cycle termination pulse for this channel
// Notes: disabled channels hold outputs low
`default_nettype none
module mpi_chan #(
	parameter int DW = mpi_pkg::DAT_W,
	parameter int CW = mpi_pkg::CNT_W
) (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_en,
	input wire logic i_term,
	input wire logic [CW-1:0] i_min_off,
	input wire logic [DW-1:0] i_comp,
	input wire logic [DW-1:0] i_ramp,
	input wire logic [DW-1:0] i_channel_current_input,
	input wire logic [DW-1:0] i_avg,
	output logic o_pwm,
	output logic o_forced,
	output logic [DW-1:0] o_samp
);
	logic [CW-1:0] off_cnt; // forced low counter
	logic samp_done; // one sample per cycle
	logic signed [DW+1:0] corr; // filtered balance error
	logic signed [DW+1:0] err;
	logic signed [DW+2:0] modv;
	// forced low timing
	always_ff @(posedge i_clk) begin
		if (i_rst || !i_en) begin
			off_cnt <= '0;
			o_forced <= 1'b0;
		end else if (i_term) begin
			off_cnt <= '0;
			o_forced <= 1'b1;
		end else if (o_forced) begin
			off_cnt <= off_cnt + 1'b1;
			if (off_cnt == i_min_off - 1'b1) o_forced <= 1'b0;
		end
	end
	assign err = $signed({2'b00, o_samp}) - $signed({2'b00, i_avg});
	assign modv = $signed({3'b000, i_comp}) - {corr[DW+1], corr};
	// pwm output
	always_ff @(posedge i_clk) begin
		if (i_rst || !i_en) begin
			o_pwm <= 1'b0;
		end else if (i_term) begin
			o_pwm <= 1'b0;
		end else if (!o_forced && !o_pwm && modv > $signed({3'b000, i_ramp})) begin
			o_pwm <= 1'b1;
		end
	end
	// sample and hold
	always_ff @(posedge i_clk) begin
		if (i_rst || !i_en) begin
			o_samp <= '0;
			samp_done <= 1'b0;
		end else if (i_term) begin
			samp_done <= 1'b0;
		end else if (o_forced && !samp_done && off_cnt == CW'(mpi_pkg::SETTLE_CYC)) begin
			o_samp <= i_channel_current_input;
			samp_done <= 1'b1;
		end
	end
	always_ff @(posedge i_clk) begin
		if (i_rst || !i_en) corr <= '0;
		else if (i_term) corr <= corr + ((err - corr) >>> mpi_pkg::FILT_SH);
	end
	chk_forced_len: assert property (@(posedge i_clk) disable iff (i_rst)
		$rose(o_forced) && i_en |-> o_forced [*8]) else $error("forced low too short");
	chk_term_low: assert property (@(posedge i_clk) disable iff (i_rst)
		i_term |=> !o_pwm) else $error("pwm not low after termination");
	chk_no_rise: assert property (@(posedge i_clk) disable iff (i_rst)
		o_forced |=> !$rose(o_pwm) || !i_en) else $error("pwm rose in forced low");
	chk_high_hold: assert property (@(posedge i_clk) disable iff (i_rst)
		o_pwm && !i_term && i_en |=> o_pwm) else $error("pwm fell without termination");
	chk_samp_win: assert property (@(posedge i_clk) disable iff (i_rst)
		$changed(o_samp) && i_en && !$past(i_rst) |-> $past(o_forced)) else $error("sample outside window");
	cov_rise: cover property (@(posedge i_clk) $rose(o_pwm));
endmodule : mpi_chan
`default_nettype wire

/* logic/mpi_pkg.sv */
// Purpose: shared constants and types for the multiphase interleaver
// Assumes: digital model of error, ramp and current samples as unsigned words
// Notes: rule summary below
// Summary of operation
// - four phases unless pins select fewer
// - cycle paced by internal cycle clock
// - cycle start forces phase one low
// - four-phase falls spaced quarter cycle
// - phase three tied high gives two phases
// - phase four tied high, phase three low, gives three phases
// - each fall held low third cycle
// - after hold, high when corrected error crosses ramp
// - high output stays high until termination
// - current sampled only inside forced low
// - one sample per cycle after settling
// - disabled channels excluded from processing
// - average equals sum over active count
// - filtered sample minus average corrects error
// - held samples exported for other consumers
// - droop current output equals average
`default_nettype none
package mpi_pkg;
	// cycle length in reference clocks, divisible by 12
	localparam int CYC_LEN = 240;
	localparam int CNT_W = 16;
	localparam int DAT_W = 12;
	// settling delay in reference clocks inside forced low
	localparam int SETTLE_CYC = 8;
	// filter shift of the balance correction
	localparam int FILT_SH = 2;
	localparam logic [1:0] RST_PCNT = 2'h3;
	typedef enum logic [1:0] {
		MPI_IDLE = 2'b00,
		MPI_RUN = 2'b01
	} mpi_state_e;
	typedef struct packed {
		logic [DAT_W-1:0] ch3;
		logic [DAT_W-1:0] ch2;
		logic [DAT_W-1:0] ch1;
		logic [DAT_W-1:0] ch0;
	} mpi_samp_s;
endpackage : mpi_pkg
`default_nettype wire

/* logic/mpi_top.sv */
// Purpose: interleaved multiphase pwm timing and current balance
// Assumes: inputs synchronous to I_REF_CLK; digital analog stand-ins
// Notes: phase count strapped from phase three/four pins before run
`default_nettype none
module mpi_top #(
	parameter int CYC = mpi_pkg::CYC_LEN,
	parameter int DW = mpi_pkg::DAT_W,
	parameter int CW = mpi_pkg::CNT_W
) (
	input wire logic I_REF_CLK,
	input wire logic I_SRST,
	input wire logic I_RUN, // start switching
	input wire logic I_PHASE3_STRAP, // phase three pin level sensed
	input wire logic I_PHASE4_STRAP, // phase four pin level sensed
	input wire logic [DW-1:0] I_ERROR_AMP_OUTPUT,
	input wire logic [DW-1:0] I_RAMP,
	input wire logic [4*DW-1:0] I_CHANNEL_CURRENT_INPUT,
	output logic O_PHASE1_DRIVE_OUT,
	output logic O_PHASE2_DRIVE_OUT,
	output logic O_PHASE3_DRIVE_OUT,
	output logic O_PHASE4_DRIVE_OUT,
	output logic O_PHASE3_OE_N, // low while driving phase three pin
	output logic O_PHASE4_OE_N, // low while driving phase four pin
	output logic [1:0] O_PHASE_COUNT_M1, // active phases minus one
	output logic O_CYCLE_START, // internal cycle clock pulse
	output logic [DW-1:0] O_AVERAGE_CHANNEL_CURRENT,
	output logic [DW-1:0] O_FEEDBACK_NODE_DROOP,
	output mpi_pkg::mpi_samp_s O_HELD_SAMPLES
);
	mpi_pkg::mpi_state_e state; // idle or running
	logic [1:0] pcnt; // latched phases minus one
	logic [CW-1:0] cyc_cnt; // position in cycle
	logic [3:0] en; // channel enables
	logic [3:0] term; // termination pulses
	logic [3:0] pwm;
	logic [3:0] forced;
	logic [DW-1:0] samp [4];
	logic [DW+1:0] sum;
	logic [CW-1:0] min_off;
	// fall offset of channel k for given count
	function automatic logic [CW-1:0] off_of(input logic [1:0] pc, input int k);
		int o;
		o = (k * CYC) / (pc + 1);
		return CW'(o);
	endfunction : off_of
	always_ff @(posedge I_REF_CLK) begin
		if (I_SRST) begin
			state <= mpi_pkg::MPI_IDLE;
			pcnt <= mpi_pkg::RST_PCNT;
		end else begin
			case (state)
				mpi_pkg::MPI_IDLE: begin
					if (I_PHASE3_STRAP) pcnt <= 2'h1;
					else if (I_PHASE4_STRAP) pcnt <= 2'h2;
					else pcnt <= 2'h3;
					if (I_RUN) state <= mpi_pkg::MPI_RUN;
				end
				mpi_pkg::MPI_RUN: begin
					if (!I_RUN) state <= mpi_pkg::MPI_IDLE;
				end
				default: state <= mpi_pkg::MPI_IDLE;
			endcase
		end
	end
	always_ff @(posedge I_REF_CLK) begin
		if (I_SRST || state != mpi_pkg::MPI_RUN) cyc_cnt <= '0;
		else if (cyc_cnt == CW'(CYC - 1)) cyc_cnt <= '0;
		else cyc_cnt <= cyc_cnt + 1'b1;
	end
	assign min_off = CW'(CYC / 3);
	generate
		for (genvar k = 0; k < 4; k++) begin : g_ch
			assign en[k] = (state == mpi_pkg::MPI_RUN) && (k <= pcnt);
			assign term[k] = en[k] && (cyc_cnt == off_of(pcnt, k));
			mpi_chan #(.DW(DW), .CW(CW)) u_ch (
				.i_clk(I_REF_CLK),
				.i_rst(I_SRST),
				.i_en(en[k]),
				.i_term(term[k]),
				.i_min_off(min_off),
				.i_comp(I_ERROR_AMP_OUTPUT),
				.i_ramp(I_RAMP),
				.i_channel_current_input(I_CHANNEL_CURRENT_INPUT[k*DW +: DW]),
				.i_avg(O_AVERAGE_CHANNEL_CURRENT),
				.o_pwm(pwm[k]),
				.o_forced(forced[k]),
				.o_samp(samp[k])
			);
		end
	endgenerate
	assign sum = (DW+2)'(samp[0]) + (DW+2)'(samp[1]) + (DW+2)'(samp[2]) + (DW+2)'(samp[3]);
	// outputs registered
	always_ff @(posedge I_REF_CLK) begin
		if (I_SRST) begin
			{O_PHASE4_DRIVE_OUT, O_PHASE3_DRIVE_OUT, O_PHASE2_DRIVE_OUT, O_PHASE1_DRIVE_OUT} <= 4'h0;
			O_PHASE3_OE_N <= 1'b1;
			O_PHASE4_OE_N <= 1'b1;
			O_PHASE_COUNT_M1 <= mpi_pkg::RST_PCNT;
			O_CYCLE_START <= 1'b0;
			O_AVERAGE_CHANNEL_CURRENT <= '0;
			O_FEEDBACK_NODE_DROOP <= '0;
			O_HELD_SAMPLES <= '0;
		end else begin
			{O_PHASE4_DRIVE_OUT, O_PHASE3_DRIVE_OUT, O_PHASE2_DRIVE_OUT, O_PHASE1_DRIVE_OUT} <= pwm;
			O_PHASE3_OE_N <= !en[2];
			O_PHASE4_OE_N <= !en[3];
			O_PHASE_COUNT_M1 <= pcnt;
			O_CYCLE_START <= term[0];
			O_AVERAGE_CHANNEL_CURRENT <= DW'(sum / ((DW+2)'(pcnt) + 1'b1));
			O_FEEDBACK_NODE_DROOP <= O_AVERAGE_CHANNEL_CURRENT;
			O_HELD_SAMPLES <= {samp[3], samp[2], samp[1], samp[0]};
		end
	end
	chk_count_hold: assert property (@(posedge I_REF_CLK) disable iff (I_SRST)
		state == mpi_pkg::MPI_RUN && $past(state) == mpi_pkg::MPI_RUN |-> $stable(pcnt)) else $error("count moved");
	chk_cycle_per: assert property (@(posedge I_REF_CLK) disable iff (I_SRST)
		term[0] && I_RUN |-> ##[1:300] term[0] || !I_RUN) else $error("cycle start missing");
	chk_quarter: assert property (@(posedge I_REF_CLK) disable iff (I_SRST)
		term[0] && pcnt == 2'h3 && I_RUN |-> ##60 (term[1] || !I_RUN)) else $error("phase two late");
	chk_dis_low: assert property (@(posedge I_REF_CLK) disable iff (I_SRST)
		!en[3] |=> !pwm[3]) else $error("disabled channel drove");
	cov_four: cover property (@(posedge I_REF_CLK) term[3]);
	cov_two: cover property (@(posedge I_REF_CLK) term[1] && pcnt == 2'h1);
	cov_three: cover property (@(posedge I_REF_CLK) term[2] && pcnt == 2'h2);
endmodule : mpi_top
`default_nettype wire

/* test/mpi_drv_model.sv */
// Purpose: gate driver stand-in feeding sensed current back
// Assumes: lower switch conducts while its drive input is low
// Notes: sense value is garbage while the upper switch is on
`default_nettype none
module mpi_drv_model (
	input wire logic [3:0] i_pwm,
	input wire logic [47:0] i_cur,
	output logic [47:0] o_sense
);
	timeunit 1ns;
	timeprecision 1ps;
	always_comb begin
		for (int k = 0; k < 4; k++) begin
			o_sense[k*12 +: 12] = i_pwm[k] ? ~i_cur[k*12 +: 12] : i_cur[k*12 +: 12];
		end
	end
endmodule : mpi_drv_model
`default_nettype wire

/* test/mpi_top_bench.sv */
// Purpose: self-checking bench for the interleaver
// Assumes: driver model returns current only during low drive
// Notes: edge times taken by a monitor in clock counts
`default_nettype none
module mpi_top_bench;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int CYC = 240;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic run = 1'b0;
	logic s3 = 1'b0;
	logic s4 = 1'b0;
	logic [11:0] comp = 12'h800;
	logic [11:0] ramp = 12'h000; // sawtooth stand-in, held flat per test
	logic [47:0] cur = {12'h0f0, 12'h110, 12'h120, 12'h100};
	logic [47:0] sense;
	logic [3:0] pwm, pwm_q, hi_seen;
	logic oe3, oe4, cs;
	logic [1:0] cnt_m1;
	logic [11:0] avg, droop;
	mpi_pkg::mpi_samp_s held;
	int fails = 0;
	int checks = 0;
	int now = 0;
	int cs_t = 0; // last cycle start time
	int cs_per = 0; // spacing of last two cycle starts
	int fall_t[4];
	int rise_t[4];
	always #2.5 clk = ~clk;
	mpi_top #(.CYC(CYC)) i_dut (.I_REF_CLK(clk), .I_SRST(rst), .I_RUN(run), .I_PHASE3_STRAP(s3),
		.I_PHASE4_STRAP(s4), .I_ERROR_AMP_OUTPUT(comp), .I_RAMP(ramp), .I_CHANNEL_CURRENT_INPUT(sense),
		.O_PHASE1_DRIVE_OUT(pwm[0]), .O_PHASE2_DRIVE_OUT(pwm[1]), .O_PHASE3_DRIVE_OUT(pwm[2]),
		.O_PHASE4_DRIVE_OUT(pwm[3]), .O_PHASE3_OE_N(oe3), .O_PHASE4_OE_N(oe4), .O_PHASE_COUNT_M1(cnt_m1),
		.O_CYCLE_START(cs), .O_AVERAGE_CHANNEL_CURRENT(avg), .O_FEEDBACK_NODE_DROOP(droop), .O_HELD_SAMPLES(held));
	mpi_drv_model i_drv (.i_pwm(pwm), .i_cur(cur), .o_sense(sense));
	// edge time stamps per phase
	always @(posedge clk) begin
		now <= now + 1;
		pwm_q <= pwm;
		hi_seen <= rst ? 4'h0 : (hi_seen | pwm);
		// cycle start spacing
		if (cs === 1'b1) begin
			cs_t <= now;
			cs_per <= now - cs_t;
		end
		for (int k = 0; k < 4; k++) begin
			if (pwm_q[k] && !pwm[k]) fall_t[k] <= now;
			if (!pwm_q[k] && pwm[k]) rise_t[k] <= now;
		end
	end
	task automatic check(input string name, input logic [47:0] seen, input logic [47:0] exp);
		checks++;
		if (seen !== exp) begin
			fails++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask : check
	task automatic finish_test();
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : finish_test
	// reset for 20 clocks with given straps
	task automatic do_reset(input logic p3, input logic p4);
		@(posedge clk);
		rst <= 1'b1;
		run <= 1'b0;
		s3 <= p3;
		s4 <= p4;
		repeat (20) @(posedge clk);
		#1;
	endtask : do_reset
	task automatic test_reset();
		do_reset(1'b0, 1'b0);
		check("pwm", pwm, 0);
		check("oe", {oe4, oe3}, 2'h3);
		check("count", cnt_m1, 2'h3);
		check("held", held, 0);
		$display("test reset done");
	endtask : test_reset
	// run n phases, flip straps mid-run
	task automatic test_cfg(input logic p3, input logic p4, input int n);
		logic [13:0] sum;
		int d;
		do_reset(p3, p4);
		@(posedge clk);
		rst <= 1'b0;
		run <= 1'b1;
		@(posedge clk);
		s3 <= ~p3;
		s4 <= ~p4;
		repeat (4*CYC) @(posedge clk);
		#1;
		sum = 0;
		check("count", cnt_m1, n - 1);
		check("oe", {oe4, oe3}, {n < 4, n < 3});
		check("cycle period", cs_per, CYC);
		for (int k = 0; k < 4; k++) begin
			if (k < n) begin
				sum += cur[k*12 +: 12];
				check("spacing", (fall_t[k] - fall_t[0] + CYC) % CYC, k * CYC / n);
				d = (rise_t[k] - fall_t[k] + CYC) % CYC;
				check("low time", d >= CYC / 3 && d <= CYC / 3 + 4, 1'b1);
				check("sample", held[k*12 +: 12], cur[k*12 +: 12]);
			end else begin
				check("idle out", hi_seen[k], 1'b0);
				check("idle samp", held[k*12 +: 12], 0);
			end
		end
		check("average", avg, sum / n);
		check("droop", droop, sum / n);
		$display("test phases %0d done", n);
	endtask : test_cfg
	// no crossing keeps all four drive outputs low
	task automatic test_no_cross();
		do_reset(1'b0, 1'b0);
		@(posedge clk);
		rst <= 1'b0;
		run <= 1'b1;
		comp <= 12'h000;
		// ramp above any corrected error, balance terms included
		ramp <= 12'hfff;
		cur <= {4{12'h100}};
		repeat (3*CYC) @(posedge clk);
		#1;
		check("no rise", hi_seen, 4'h0);
		$display("test no crossing done");
	endtask : test_no_cross
	initial begin
		test_reset();
		test_cfg(1'b0, 1'b0, 4);
		test_cfg(1'b0, 1'b1, 3);
		test_cfg(1'b1, 1'b0, 2);
		test_cfg(1'b1, 1'b1, 2);
		test_no_cross();
		finish_test();
	end
	// hang guard
	initial begin
		repeat (30*CYC) @(posedge clk);
		fails++;
		finish_test();
	end
endmodule : mpi_top_bench
`default_nettype wire
